// [design/compact_timer_pwm.sv]
// compact timer counter core with compare, timer/counter and pwm output modes
`timescale 1ns/1ps
`default_nettype none

// ********************************
// Overview of operation
// - mode_select 11 selects timer/counter mode.
// - timer/counter mode counts and flags like compare mode, pin undriven.
// - timer/counter mode releases the output pin for other uses.
// - mode_select 10 selects pwm output mode.
// - clear_select is ignored in pwm mode.
// - pwm period comparator clears counter; other comparator sets duty.
// - period_duty_swap picks which compare value is period or duty.
// - pwm mode sets match_a_flag and match_p_flag on their matches.
// - output_function_select enables wave or forces pin high or low.
// - output_level_control picks active high or active low wave.
// - output_invert flips the pin after polarity selection.
// - swap 0: period compare_p_value*256 (zero gives 65536), duty compare_a_value.
// - duty at or above period keeps output active whole period.
// - swap 1: period compare_a_value, duty compare_p_value*256 or 65536.
// - each counter clear starts a new period with active phase, except with swap 0 and compare_a_value zero.
// - counting, compares and flags continue while pin is forced.
// - compare_p_value matches only the counter upper byte.
// - clear_select high in compare or timer/counter mode: A match clears counter, no match_p_flag ever.
// - clear_select high, compare_a_value zero: overflow raises no A flag.
// - counter_on rise zeroes counter; fall stops and holds value.
// ********************************

module compact_timer_pwm
	import compact_timer_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// selected timer clock tick, one cycle wide
	input wire logic count_tick,
	// timer_control_1 fields
	input wire logic mode_select_hi,
	input wire logic mode_select_lo,
	input wire logic output_function_select_hi,
	input wire logic output_function_select_lo,
	input wire logic output_level_control,
	input wire logic output_invert,
	input wire logic period_duty_swap,
	input wire logic clear_select,
	// run control
	input wire logic counter_on,
	// compare values
	input wire logic [compact_timer_pkg::CNT_W-1:0] compare_a_value,
	input wire logic [compact_timer_pkg::PCMP_W-1:0] compare_p_value,
	// flag clear strobes from software
	input wire logic match_a_clear,
	input wire logic match_p_clear,
	// status
	output logic [compact_timer_pkg::CNT_W-1:0] count_value_q,
	output logic match_a_flag_q,
	output logic match_p_flag_q,
	// output pin, enable low while driving
	output logic pin_out_q,
	output logic pin_oe_b_q
);
	import compact_timer_pkg::*;

	// ********************************
	// decode
	// ********************************
	mode_t mode;
	logic [1:0] io_sel;
	logic on_prev_q;
	logic on_rise;
	logic run_tick;
	logic pwm_mode;
	logic cmp_like;

	// mode field decoded as one enum
	assign mode = mode_t'({mode_select_hi, mode_select_lo});
	assign io_sel = {output_function_select_hi, output_function_select_lo};
	assign pwm_mode = (mode == MODE_PWM);
	// timer/counter mode shares the compare engine
	assign cmp_like = (mode == MODE_COMPARE) || (mode == MODE_TIMER);

	// counter_on edge detect, control bits are same-domain
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			on_prev_q <= 1'b0;
		end else begin
			on_prev_q <= counter_on;
		end
	end

	assign on_rise = counter_on && !on_prev_q;
	// a tick in the rise cycle is lost on purpose: the rise zeroes
	assign run_tick = counter_on && on_prev_q && count_tick;

	// ********************************
	// comparators
	// ********************************
	logic [15:0] cnt_next;
	logic eq_a;
	logic hit_a;
	logic hit_p;
	logic clr_cnt;

	assign cnt_next = count_value_q + CNT_STEP;
	assign eq_a = (cnt_next == compare_a_value);
	// zero A value never raises a flag; the wrap is a plain overflow
	assign hit_a = run_tick && eq_a && (compare_a_value != ACMP_ZERO);
	// only the upper byte is compared, so matches land on 256 multiples
	assign hit_p = run_tick && (cnt_next[7:0] == LOW_BYTE_ZERO)
		&& (cnt_next[15:PCMP_SHIFT] == compare_p_value);

	// clear source per mode
	always_comb begin
		clr_cnt = 1'b0;
		case (mode)
			MODE_PWM: begin
				// clear_select plays no part here
				if (period_duty_swap) begin
					clr_cnt = run_tick && eq_a;
				end else begin
					clr_cnt = hit_p;
				end
			end
			MODE_COMPARE, MODE_TIMER: begin
				if (clear_select) begin
					clr_cnt = hit_a;
				end else begin
					clr_cnt = hit_p;
				end
			end
			default: begin
				clr_cnt = 1'b0;
			end
		endcase
	end

	// ********************************
	// counter
	// ********************************
	// rise zeroes, fall holds, ticks add one and wrap
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			count_value_q <= CNT_RST;
		end else if (on_rise) begin
			count_value_q <= CNT_RST;
		end else if (run_tick) begin
			if (clr_cnt) begin
				count_value_q <= CNT_RST;
			end else begin
				count_value_q <= cnt_next;
			end
		end
	end

	// ********************************
	// match flags
	// ********************************
	logic set_a;
	logic set_p;

	// capture mode is outside this block, so it raises nothing
	assign set_a = hit_a && (pwm_mode || cmp_like);
	assign set_p = hit_p && (pwm_mode || (cmp_like && !clear_select));

	// a set in the clear cycle wins so no match is lost
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			match_a_flag_q <= 1'b0;
		end else if (set_a) begin
			match_a_flag_q <= 1'b1;
		end else if (match_a_clear) begin
			match_a_flag_q <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			match_p_flag_q <= 1'b0;
		end else if (set_p) begin
			match_p_flag_q <= 1'b1;
		end else if (match_p_clear) begin
			match_p_flag_q <= 1'b0;
		end
	end

	// ********************************
	// pwm waveform
	// ********************************
	logic [16:0] duty_span;
	logic pwm_active;
	logic pwm_lvl;
	logic force_lvl_off;
	logic force_lvl_on;

	// duty in timer clocks, 17 bits so 65536 fits
	always_comb begin
		if (period_duty_swap) begin
			if (compare_p_value == PCMP_ZERO) begin
				duty_span = FULL_SPAN;
			end else begin
				duty_span = {1'b0, compare_p_value, LOW_BYTE_ZERO};
			end
		end else begin
			duty_span = {1'b0, compare_a_value};
		end
	end

	// count never reaches period, so duty >= period stays active
	assign pwm_active = ({1'b0, count_value_q} < duty_span);
	// polarity first, inversion after
	assign pwm_lvl = (pwm_active ? output_level_control : !output_level_control)
		^ output_invert;
	assign force_lvl_off = !output_level_control ^ output_invert;
	assign force_lvl_on = output_level_control ^ output_invert;

	// ********************************
	// compare mode pin level
	// ********************************
	logic cmp_lvl_q;

	// preset on counter_on rise, changed only by an A flag event
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			cmp_lvl_q <= 1'b0;
		end else if (on_rise) begin
			cmp_lvl_q <= output_level_control;
		end else if (hit_a && mode == MODE_COMPARE) begin
			case (io_sel)
				CMP_IO_LOW: cmp_lvl_q <= 1'b0;
				CMP_IO_HIGH: cmp_lvl_q <= 1'b1;
				CMP_IO_TOGGLE: cmp_lvl_q <= !cmp_lvl_q;
				default: cmp_lvl_q <= cmp_lvl_q;
			endcase
		end
	end

	// ********************************
	// output pin
	// ********************************
	// registered so the pin lags the counter by one cycle
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			pin_out_q <= 1'b0;
			pin_oe_b_q <= 1'b1;
		end else begin
			case (mode)
				MODE_PWM: begin
					pin_oe_b_q <= 1'b0;
					case (io_sel)
						PWM_IO_INACTIVE: pin_out_q <= force_lvl_off;
						PWM_IO_ACTIVE: pin_out_q <= force_lvl_on;
						PWM_IO_WAVE: pin_out_q <= pwm_lvl;
						// single pulse is not built here; hold inactive
						default: pin_out_q <= force_lvl_off;
					endcase
				end
				MODE_COMPARE: begin
					pin_oe_b_q <= 1'b0;
					pin_out_q <= cmp_lvl_q ^ output_invert;
				end
				MODE_TIMER: begin
					pin_oe_b_q <= 1'b1;
					pin_out_q <= 1'b0;
				end
				default: begin
					pin_oe_b_q <= 1'b1;
					pin_out_q <= 1'b0;
				end
			endcase
		end
	end

	// ********************************
	// checks
	// ********************************
	AST_ON_RISE_ZERO: assert property (@(posedge sys_clk) disable iff (!rst_b)
		on_rise |=> (count_value_q == CNT_RST))
		else $error("counter not zeroed on counter_on rise");

	AST_OFF_HOLDS: assert property (@(posedge sys_clk) disable iff (!rst_b)
		!counter_on |=> $stable(count_value_q))
		else $error("counter moved while off");

	AST_INCREMENT: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(run_tick && !clr_cnt) |=> (count_value_q == $past(cnt_next)))
		else $error("counter did not step by one");

	AST_PWM_PERIOD_CLEAR: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(pwm_mode && !period_duty_swap && hit_p) |=> (count_value_q == CNT_RST))
		else $error("pwm period match did not clear counter");

	AST_PWM_SWAP_CLEAR: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(pwm_mode && period_duty_swap && run_tick && eq_a && !on_rise)
		|=> (count_value_q == CNT_RST))
		else $error("swapped pwm period match did not clear counter");

	AST_FLAG_A: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(pwm_mode && hit_a) |=> match_a_flag_q)
		else $error("match_a_flag missed");

	AST_FLAG_P: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(pwm_mode && hit_p) |=> match_p_flag_q)
		else $error("match_p_flag missed");

	AST_NO_P_ON_A_CLEAR: assert property (@(posedge sys_clk) disable iff (!rst_b)
		$rose(match_p_flag_q) |-> !($past(cmp_like) && $past(clear_select)))
		else $error("match_p_flag raised with clear_select high");

	AST_ZERO_A_NO_FLAG: assert property (@(posedge sys_clk) disable iff (!rst_b)
		$rose(match_a_flag_q) |-> ($past(compare_a_value) != ACMP_ZERO))
		else $error("match_a_flag raised for zero compare value");

	AST_TIMER_RELEASE: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(mode == MODE_TIMER) |=> pin_oe_b_q)
		else $error("pin driven in timer mode");

	AST_PWM_WAVE: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(pwm_mode && io_sel == PWM_IO_WAVE) |=> (!pin_oe_b_q && pin_out_q == $past(pwm_lvl)))
		else $error("pwm pin level wrong");

	AST_FORCE_OFF: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(pwm_mode && io_sel == PWM_IO_INACTIVE) |=> (pin_out_q == $past(force_lvl_off)))
		else $error("forced inactive level wrong");

	AST_PERIOD_START_ACTIVE: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(pwm_mode && io_sel == PWM_IO_WAVE && count_value_q == CNT_RST
		&& duty_span != 17'h00000)
		|=> (pin_out_q == $past(output_level_control ^ output_invert)))
		else $error("period did not start active");

endmodule

`default_nettype wire

// [design/ctm_pkg.sv]
// constants and types shared by the compact timer pwm block
package compact_timer_pkg;

	// ********************************
	// operating modes
	// ********************************
	typedef enum logic [1:0] {
		MODE_COMPARE = 2'b00,
		MODE_CAPTURE = 2'b01,
		MODE_PWM = 2'b10,
		MODE_TIMER = 2'b11
	} mode_t;

	// ********************************
	// output function codes
	// ********************************
	// compare match output mode
	localparam logic [1:0] CMP_IO_KEEP = 2'b00;
	localparam logic [1:0] CMP_IO_LOW = 2'b01;
	localparam logic [1:0] CMP_IO_HIGH = 2'b10;
	localparam logic [1:0] CMP_IO_TOGGLE = 2'b11;
	// pwm mode
	localparam logic [1:0] PWM_IO_INACTIVE = 2'b00;
	localparam logic [1:0] PWM_IO_ACTIVE = 2'b01;
	localparam logic [1:0] PWM_IO_WAVE = 2'b10;
	localparam logic [1:0] PWM_IO_PULSE = 2'b11;

	// ********************************
	// widths and reset values
	// ********************************
	localparam int CNT_W = 16;
	localparam int PCMP_W = 8;
	localparam int PCMP_SHIFT = 8;
	localparam logic [15:0] CNT_RST = 16'h0000;
	localparam logic [15:0] CNT_STEP = 16'h0001;
	localparam logic [15:0] ACMP_ZERO = 16'h0000;
	localparam logic [7:0] PCMP_ZERO = 8'h00;
	localparam logic [7:0] LOW_BYTE_ZERO = 8'h00;
	localparam logic [16:0] FULL_SPAN = 17'h10000;

endpackage

// [tb/compact_timer_pwm_tb.sv]
// self-checking bench for the compact timer pwm block
`timescale 1ns/1ps
`default_nettype none

module compact_timer_pwm_tb;
	import compact_timer_pkg::*;
	logic sys_clk = 1'b0, rst_b = 1'b0, tick = 1'b1, ms_hi = 1'b0, ms_lo = 1'b0;
	logic io_hi = 1'b0, io_lo = 1'b0, oc = 1'b0, inv = 1'b0, swap = 1'b0, csel = 1'b0;
	logic run = 1'b0, a_clr = 1'b0, p_clr = 1'b0, hclr = 1'b0;
	logic [15:0] ca = 16'h0000, cnt, v;
	logic [7:0] cp = 8'h00;
	logic fa, fp, pout, poe_b, lvl;
	logic [16:0] hcnt;
	int fail_count = 0;
	int n_tests = 0;

	always #12.5 sys_clk = ~sys_clk;

	compact_timer_pwm u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .count_tick(tick),
		.mode_select_hi(ms_hi), .mode_select_lo(ms_lo), .output_function_select_hi(io_hi),
		.output_function_select_lo(io_lo), .output_level_control(oc), .output_invert(inv),
		.period_duty_swap(swap), .clear_select(csel), .counter_on(run),
		.compare_a_value(ca), .compare_p_value(cp), .match_a_clear(a_clr),
		.match_p_clear(p_clr), .count_value_q(cnt), .match_a_flag_q(fa),
		.match_p_flag_q(fp), .pin_out_q(pout), .pin_oe_b_q(poe_b));

	pin_load u_load (.sys_clk(sys_clk), .pin_out_q(pout), .pin_oe_b_q(poe_b),
		.high_clr(hclr), .pin_level(lvl), .high_cnt_q(hcnt));

	// ********************************
	// helpers
	// ********************************
	// inputs always change a fixed 1 ns after the rising edge
	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// clears both flags and the driven-high cycle count in one cycle
	task automatic clr_all();
		a_clr = 1'b1;
		p_clr = 1'b1;
		hclr = 1'b1;
		step(1);
		a_clr = 1'b0;
		p_clr = 1'b0;
		hclr = 1'b0;
	endtask

	// any window of one whole period holds exactly the driven-high cycles of it
	task automatic pwm(input logic s, input logic [7:0] p, input logic [15:0] a,
		input logic [4:0] cfg, input int per, input int hi, input logic [1:0] fl);
		run = 1'b0;
		step(1);
		{ms_hi, ms_lo, swap, cp, ca} = {2'b10, s, p, a};
		{csel, oc, inv, io_hi, io_lo} = cfg;
		run = 1'b1;
		step(per + 4);
		clr_all();
		step(per);
		chk(32'(hcnt), hi);
		chk({fa, fp}, fl);
	endtask

	task automatic wrap_up();
		$display("tests=%0d errors=%0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// ********************************
	// tests
	// ********************************
	initial begin
		step(20);
		rst_b = 1'b1;
		chk({cnt, fa, fp, poe_b}, 19'h00001);
		pwm(0, 8'h01, 16'h0080, 5'b01010, 256, 128, 2'b11);
		pwm(0, 8'h01, 16'h0040, 5'b01010, 256, 64, 2'b11);
		pwm(0, 8'h01, 16'h0040, 5'b00010, 256, 192, 2'b11);
		pwm(0, 8'h01, 16'h0040, 5'b01110, 256, 192, 2'b11);
		pwm(0, 8'h01, 16'h0040, 5'b11010, 256, 64, 2'b11);
		pwm(0, 8'h01, 16'h0200, 5'b01010, 256, 256, 2'b01);
		pwm(0, 8'h01, 16'h0040, 5'b01000, 256, 0, 2'b11);
		pwm(0, 8'h01, 16'h0040, 5'b01001, 256, 256, 2'b11);
		pwm(1, 8'h01, 16'h0300, 5'b01010, 768, 256, 2'b11);
		// timer/counter mode with clear on A
		run = 1'b0;
		step(1);
		// a P match at 0x100 falls inside the A period and must stay silent
		{ms_hi, ms_lo, csel, cp, ca} = {3'b111, 8'h01, 16'h0110};
		run = 1'b1;
		step(2);
		clr_all();
		repeat (300) begin
			step(1);
			chk(poe_b, 1'b1);
			chk(cnt < 16'h0110, 1'b1);
		end
		chk({fa, fp}, 2'b10);
		// a zero A value: full 16-bit wrap without an A flag
		run = 1'b0;
		ca = 16'h0000;
		step(1);
		run = 1'b1;
		clr_all();
		step(65540);
		chk({fa, fp}, 2'b00);
		run = 1'b0;
		step(1);
		v = cnt;
		step(5);
		chk(cnt, v);
		run = 1'b1;
		step(1);
		chk(cnt, 16'h0000);
		step(3);
		chk(cnt, 16'h0003);
		// compare mode, toggle on each A match: half the cycles high
		run = 1'b0;
		step(1);
		{ms_hi, ms_lo, io_hi, io_lo, oc, inv, ca} = {6'b001100, 16'h0010};
		run = 1'b1;
		step(40);
		clr_all();
		step(32);
		chk(32'(hcnt), 16);
		chk({fa, fp}, 2'b10);
		// capture mode is inert here: pin released, no flags
		{ms_hi, ms_lo} = 2'b01;
		clr_all();
		step(40);
		chk({fa, fp, poe_b}, 3'b001);
		wrap_up();
	end

	// whole run is about 72k cycles
	initial begin
		#(25 * 90000);
		fail_count++;
		wrap_up();
	end
endmodule

`default_nettype wire

// [tb/pin_load.sv]
// load on the timer output pin: resolves the line and counts driven-high cycles
`timescale 1ns/1ps
`default_nettype none

module pin_load (
	// clock
	input wire logic sys_clk,
	// pin from the timer
	input wire logic pin_out_q,
	input wire logic pin_oe_b_q,
	// measurement
	input wire logic high_clr,
	output logic pin_level,
	output logic [16:0] high_cnt_q
);
	logic last_q = 1'b0;

	// no pull on this line: a released pin shows the inverse of its last level
	assign pin_level = pin_oe_b_q ? ~last_q : pin_out_q;

	// remember the last level seen on the line
	always_ff @(posedge sys_clk) begin
		last_q <= pin_level;
	end

	// count only cycles the timer itself drives high, never a floating level
	always_ff @(posedge sys_clk) begin
		if (high_clr) begin
			high_cnt_q <= 17'h00000;
		end else if (pin_level && !pin_oe_b_q) begin
			high_cnt_q <= high_cnt_q + 17'h00001;
		end
	end
endmodule

`default_nettype wire
